//--- rtl/nic_regs_pkg.sv
package nic_regs_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] BUS_PERF_COUNTER_OFS       = 8'h8C;
   localparam logic [7:0] POWER_MGMT_CTRL_STATUS_OFS = 8'h90;
   localparam logic [7:0] CURRENT_TX_DESC_PTR_OFS    = 8'h94;
   localparam logic [7:0] CURRENT_RX_DESC_PTR_OFS    = 8'h98;
   localparam logic [7:0] TX_BURST_COUNT_TIMEOUT_OFS = 8'h9C;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int CLK_COUNT_LSB     = 16;
   localparam int CLK_COUNT_W       = 16;
   localparam int WORD_COUNT_LSB    = 0;
   localparam int WORD_COUNT_W      = 8;
   localparam int WAKE_STATUS_BIT   = 15;
   localparam int WAKE_ENABLE_BIT   = 8;
   localparam int POWER_STATE_LSB   = 0;
   localparam int POWER_STATE_W     = 2;
   localparam int BURST_COUNT_LSB   = 16;
   localparam int BURST_COUNT_W     = 5;
   localparam int TIMEOUT_LSB       = 0;
   localparam int TIMEOUT_W         = 12;
   localparam int PM_CFG_W          = 16;

   // ------------------------------------------------------------
   // Reset values and encodings
   // ------------------------------------------------------------
   localparam logic [31:0]              REG_RESET_VALUE = 32'h0000_0000;
   localparam logic [POWER_STATE_W-1:0] POWER_D0        = 2'h0;
   localparam logic [POWER_STATE_W-1:0] POWER_D3HOT     = 2'h3;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS       = 10000;
   localparam int TICK_FAST_PS        = 2560000;   // 2.56 us at 100 Mb/s
   localparam int TICK_SLOW_PS        = 25600000;  // 25.6 us at 10 Mb/s
   localparam int TICK_FAST_CYCLES    = TICK_FAST_PS / CLK_PERIOD_PS;
   localparam int TICK_SLOW_CYCLES    = TICK_SLOW_PS / CLK_PERIOD_PS;
   localparam int TICK_CNT_W          = 12;

endpackage : nic_regs_pkg

//--- rtl/timeout_tick_divider.sv
`timescale 1ns/1ps
module timeout_tick_divider
   import nic_regs_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic reset_i,
   // Control
   input  wire logic speed_100_i,
   input  wire logic run_i,
   // Tick
   output logic      tick_o
);

   logic [TICK_CNT_W-1:0] count_reg;
   logic [TICK_CNT_W-1:0] count_next;
   logic [TICK_CNT_W-1:0] period_last;
   logic                  wrap;

   // ------------------------------------------------------------
   // Period select
   // ------------------------------------------------------------
   assign period_last = speed_100_i ? TICK_CNT_W'(TICK_FAST_CYCLES - 1) : TICK_CNT_W'(TICK_SLOW_CYCLES - 1);
   assign wrap        = run_i && (count_reg >= period_last);
   // Counter parks at zero while idle so the first tick is a full period away
   assign count_next  = !run_i ? '0 : wrap ? '0 : count_reg + 1'b1;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_reg <= '0;
         tick_o    <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_o    <= wrap;
      end
   end

endmodule : timeout_tick_divider

//--- rtl/nic_perf_pm_txtimer_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Clock count sums cycles of read requests since last counter read.
// - Both counter fields read-only; a read returns them, then zeroes them.
// - Word count sums words moved by bus-master transfers since last read.
// - Wake status sets on any wake event, regardless of wake enable.
// - Writing one clears wake status and stops PME drive; zero does nothing.
// - Wake status resets to zero.
// - Wake enable gates PME drive and resets to zero.
// - Power state field reads and writes D0 and D3hot only; D1 and D2 unsupported by default.
// - Unsupported power state write completes but leaves state unchanged.
// - Data scale and data select read as zero, not writable.
// - Read-only register shows current transmit descriptor address.
// - Read-only register shows current receive descriptor address.
// - Transmit-completed interrupt every burst-count successful transmissions, repeating.
// - Enabled timeout counts down each 2.56 us or 25.6 us.
// - Timeout reaching zero before next transmit start raises timeout interrupt.
// - Config-space and CSR power register share one storage.
// - Bus reset rising edge clears power state when control bit set.
// - Sticky select keeps PME until cleared; else power-up drops it.
module nic_perf_pm_txtimer_regs
   import nic_regs_pkg::*;
#(
   parameter logic [3:0] SUPPORTED_STATES = 4'h9
)
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   // CSR access
   input  wire logic                 csr_wr_i,
   input  wire logic                 csr_rd_i,
   input  wire logic [7:0]           csr_addr_i,
   input  wire logic [31:0]          csr_wdata_i,
   output logic      [31:0]          csr_rdata_o,
   output logic                      csr_rvalid_o,
   // Configuration-space power register
   input  wire logic                 cfg_pm_wr_i,
   input  wire logic [PM_CFG_W-1:0]  cfg_pm_wdata_i,
   output logic      [PM_CFG_W-1:0]  cfg_pm_rdata_o,
   // Bus activity
   input  wire logic                 read_req_i,
   input  wire logic                 master_word_i,
   // Descriptor pointers
   input  wire logic [31:0]          tx_desc_current_i,
   input  wire logic [31:0]          rx_desc_current_i,
   // Wake logic
   input  wire logic                 wake_event_i,
   input  wire logic                 power_up_i,
   input  wire logic                 sticky_wake_select_i,
   input  wire logic                 reset_clears_power_state_i,
   input  wire logic                 bus_reset_level_i,
   output logic                      pme_n_o,
   output logic                      pme_oe_o,
   // Transmit events
   input  wire logic                 tx_success_i,
   input  wire logic                 tx_start_i,
   input  wire logic                 speed_100_i,
   input  wire logic                 tx_timeout_irq_enable_i,
   output logic                      tx_complete_irq_o,
   output logic                      tx_timeout_irq_o
);

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   logic                     perf_read;
   logic                     pm_csr_write;
   logic                     txbr_write;
   assign perf_read    = csr_rd_i && hit(csr_addr_i, BUS_PERF_COUNTER_OFS);
   assign pm_csr_write = csr_wr_i && hit(csr_addr_i, POWER_MGMT_CTRL_STATUS_OFS);
   assign txbr_write   = csr_wr_i && hit(csr_addr_i, TX_BURST_COUNT_TIMEOUT_OFS);

   // ------------------------------------------------------------
   // Performance counter
   // ------------------------------------------------------------
   logic [CLK_COUNT_W-1:0]   read_latency_clock_count_reg;
   logic [CLK_COUNT_W-1:0]   read_latency_clock_count_next;
   logic [WORD_COUNT_W-1:0]  master_word_count_reg;
   logic [WORD_COUNT_W-1:0]  master_word_count_next;
   logic [CLK_COUNT_W-1:0]   clk_base;
   logic [WORD_COUNT_W-1:0]  word_base;

   // A read zeroes the base, but an event in the same cycle still counts
   assign clk_base  = perf_read ? '0 : read_latency_clock_count_reg;
   assign word_base = perf_read ? '0 : master_word_count_reg;
   assign read_latency_clock_count_next = (read_req_i && !(&clk_base)) ? clk_base + 1'b1 : clk_base;
   assign master_word_count_next = (master_word_i && !(&word_base)) ? word_base + 1'b1 : word_base;

   // ------------------------------------------------------------
   // Power management, shared by CSR and config paths
   // ------------------------------------------------------------
   logic [POWER_STATE_W-1:0] power_state_reg;
   logic [POWER_STATE_W-1:0] power_state_next;
   logic                     wake_enable_reg;
   logic                     wake_enable_next;
   logic                     wake_status_reg;
   logic                     wake_status_next;
   logic                     pme_drive_next;
   logic                     bus_reset_prev_reg;
   logic                     bus_reset_rise;
   logic                     pm_write;
   logic [PM_CFG_W-1:0]      pm_data;
   logic                     state_ok;
   logic                     wake_clear;

   // CSR path wins if both arrive together; either lands in the same flops
   assign pm_write   = pm_csr_write || cfg_pm_wr_i;
   assign pm_data    = pm_csr_write ? csr_wdata_i[PM_CFG_W-1:0] : cfg_pm_wdata_i;
   assign state_ok   = SUPPORTED_STATES[pm_data[POWER_STATE_LSB +: POWER_STATE_W]];
   assign bus_reset_rise = bus_reset_level_i && !bus_reset_prev_reg;
   assign wake_clear = pm_write && pm_data[WAKE_STATUS_BIT];

   assign power_state_next = (bus_reset_rise && reset_clears_power_state_i) ? POWER_D0 :
                             (pm_write && state_ok) ? pm_data[POWER_STATE_LSB +: POWER_STATE_W] :
                             power_state_reg;
   assign wake_enable_next = pm_write ? pm_data[WAKE_ENABLE_BIT] : wake_enable_reg;
   // Set wins over clear so a wake in the clearing cycle is kept
   assign wake_status_next = wake_event_i ? 1'b1 : wake_clear ? 1'b0 : wake_status_reg;
   // Enable low always wins, so PME is never driven while it is forbidden
   assign pme_drive_next   = !wake_enable_next ? 1'b0 :
                             wake_event_i ? 1'b1 :
                             wake_clear ? 1'b0 :
                             (!sticky_wake_select_i && power_up_i) ? 1'b0 :
                             pme_oe_o;

   logic [PM_CFG_W-1:0]      pm_word;
   always_comb begin
      pm_word = '0;
      pm_word[WAKE_STATUS_BIT] = wake_status_reg;
      pm_word[WAKE_ENABLE_BIT] = wake_enable_reg;
      pm_word[POWER_STATE_LSB +: POWER_STATE_W] = power_state_reg;
   end

   // ------------------------------------------------------------
   // Transmit burst count and time-out
   // ------------------------------------------------------------
   logic [BURST_COUNT_W-1:0] tx_burst_interrupt_count_reg;
   logic [TIMEOUT_W-1:0]     tx_timeout_value_reg;
   logic [BURST_COUNT_W-1:0] burst_seen_reg;
   logic [BURST_COUNT_W-1:0] burst_seen_next;
   logic [TIMEOUT_W-1:0]     timer_reg;
   logic [TIMEOUT_W-1:0]     timer_next;
   logic                     timer_armed_reg;
   logic                     timer_armed_next;
   logic                     burst_done;
   logic                     timer_expire;
   logic                     tick;

   // A burst count of zero never fires
   assign burst_done = tx_success_i && (tx_burst_interrupt_count_reg != '0) &&
                       (burst_seen_reg + 1'b1 == tx_burst_interrupt_count_reg);
   assign burst_seen_next = burst_done ? '0 : tx_success_i ? burst_seen_reg + 1'b1 : burst_seen_reg;

   timeout_tick_divider u_tick (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .speed_100_i (speed_100_i),
      .run_i       (tx_timeout_irq_enable_i),
      .tick_o      (tick)
   );

   assign timer_expire = tx_timeout_irq_enable_i && timer_armed_reg && (timer_reg == '0) && !tx_start_i;
   assign timer_next   = tx_start_i ? tx_timeout_value_reg :
                         (tx_timeout_irq_enable_i && tick && timer_reg != '0) ? timer_reg - 1'b1 :
                         timer_reg;
   assign timer_armed_next = tx_start_i ? 1'b1 : timer_expire ? 1'b0 : timer_armed_reg;

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   logic [31:0]              read_word;
   always_comb begin
      read_word = '0;
      if (hit(csr_addr_i, BUS_PERF_COUNTER_OFS)) begin
         read_word[CLK_COUNT_LSB +: CLK_COUNT_W]   = read_latency_clock_count_reg;
         read_word[WORD_COUNT_LSB +: WORD_COUNT_W] = master_word_count_reg;
      end else if (hit(csr_addr_i, POWER_MGMT_CTRL_STATUS_OFS)) begin
         read_word[PM_CFG_W-1:0] = pm_word;
      end else if (hit(csr_addr_i, CURRENT_TX_DESC_PTR_OFS)) begin
         read_word = tx_desc_current_i;
      end else if (hit(csr_addr_i, CURRENT_RX_DESC_PTR_OFS)) begin
         read_word = rx_desc_current_i;
      end else if (hit(csr_addr_i, TX_BURST_COUNT_TIMEOUT_OFS)) begin
         read_word[BURST_COUNT_LSB +: BURST_COUNT_W] = tx_burst_interrupt_count_reg;
         read_word[TIMEOUT_LSB +: TIMEOUT_W]         = tx_timeout_value_reg;
      end
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         read_latency_clock_count_reg <= REG_RESET_VALUE[CLK_COUNT_LSB +: CLK_COUNT_W];
         master_word_count_reg        <= REG_RESET_VALUE[WORD_COUNT_LSB +: WORD_COUNT_W];
         power_state_reg              <= REG_RESET_VALUE[POWER_STATE_LSB +: POWER_STATE_W];
         wake_enable_reg              <= REG_RESET_VALUE[WAKE_ENABLE_BIT];
         wake_status_reg              <= REG_RESET_VALUE[WAKE_STATUS_BIT];
         bus_reset_prev_reg           <= 1'b0;
         pme_oe_o                     <= 1'b0;
      end else begin
         read_latency_clock_count_reg <= read_latency_clock_count_next;
         master_word_count_reg        <= master_word_count_next;
         power_state_reg              <= power_state_next;
         wake_enable_reg              <= wake_enable_next;
         wake_status_reg              <= wake_status_next;
         bus_reset_prev_reg           <= bus_reset_level_i;
         pme_oe_o                     <= pme_drive_next;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         tx_burst_interrupt_count_reg <= REG_RESET_VALUE[BURST_COUNT_LSB +: BURST_COUNT_W];
         tx_timeout_value_reg         <= REG_RESET_VALUE[TIMEOUT_LSB +: TIMEOUT_W];
         burst_seen_reg               <= '0;
         timer_reg                    <= '0;
         timer_armed_reg              <= 1'b0;
         tx_complete_irq_o            <= 1'b0;
         tx_timeout_irq_o             <= 1'b0;
      end else begin
         if (txbr_write) begin
            tx_burst_interrupt_count_reg <= csr_wdata_i[BURST_COUNT_LSB +: BURST_COUNT_W];
            tx_timeout_value_reg         <= csr_wdata_i[TIMEOUT_LSB +: TIMEOUT_W];
         end
         burst_seen_reg    <= burst_seen_next;
         timer_reg         <= timer_next;
         timer_armed_reg   <= timer_armed_next;
         tx_complete_irq_o <= burst_done;
         tx_timeout_irq_o  <= timer_expire;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         csr_rdata_o    <= '0;
         csr_rvalid_o   <= 1'b0;
         cfg_pm_rdata_o <= '0;
         pme_n_o        <= 1'b1;
      end else begin
         csr_rdata_o    <= csr_rd_i ? read_word : '0;
         csr_rvalid_o   <= csr_rd_i;
         cfg_pm_rdata_o <= pm_word;
         pme_n_o        <= 1'b0;   // Open drain: only the enable toggles
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   perf_read_clears_a: assert property (perf_read && !read_req_i && !master_word_i |=>
      read_latency_clock_count_reg == '0 && master_word_count_reg == '0) else $error("counter not cleared");
   clk_count_inc_a: assert property (read_req_i && !perf_read && !(&read_latency_clock_count_reg) |=>
      read_latency_clock_count_reg == $past(read_latency_clock_count_reg) + 1'b1) else $error("clock count");
   word_count_sat_a: assert property ((&master_word_count_reg) && !perf_read |=>
      &master_word_count_reg) else $error("word count wrapped");
   word_count_inc_a: assert property (master_word_i && !perf_read && !(&master_word_count_reg) |=>
      master_word_count_reg == $past(master_word_count_reg) + 1'b1) else $error("word count");
   wake_status_set_a: assert property (wake_event_i |=> wake_status_reg) else $error("wake lost");
   wake_clear_a: assert property (wake_clear && !wake_event_i |=> !wake_status_reg && !pme_oe_o)
      else $error("wake not cleared");
   pme_needs_enable_a: assert property (pme_oe_o |-> wake_enable_reg) else $error("pme w/o enable");
   bad_state_kept_a: assert property (pm_write && !state_ok && !bus_reset_rise |=>
      $stable(power_state_reg)) else $error("bad state taken");
   reset_clears_state_a: assert property (bus_reset_rise && reset_clears_power_state_i |=>
      power_state_reg == POWER_D0) else $error("state not cleared");
   sticky_pme_a: assert property (pme_oe_o && sticky_wake_select_i && !wake_clear && wake_enable_next |=>
      pme_oe_o) else $error("sticky pme dropped");
   timer_reload_a: assert property (tx_start_i |=> timer_reg == $past(tx_timeout_value_reg))
      else $error("timer not reloaded");
   timer_hold_a: assert property (!tx_timeout_irq_enable_i && !tx_start_i |=> $stable(timer_reg))
      else $error("timer moved");
   timeout_irq_a: assert property (timer_expire |=> tx_timeout_irq_o ##1 !tx_timeout_irq_o)
      else $error("timeout irq");
   burst_irq_a: assert property (tx_complete_irq_o |-> $past(tx_success_i)) else $error("burst irq");
   power_state_write_a: assert property (pm_write && state_ok && !bus_reset_rise |=>
      power_state_reg == $past(pm_data[POWER_STATE_LSB +: POWER_STATE_W])) else $error("state write lost");
   wake_enable_kept_a: assert property (!pm_write |=> $stable(wake_enable_reg))
      else $error("wake enable moved");
   burst_zero_quiet_a: assert property (tx_burst_interrupt_count_reg == '0 |=> !tx_complete_irq_o)
      else $error("burst irq at zero");
   timeout_gated_a: assert property (!tx_timeout_irq_enable_i |=> !tx_timeout_irq_o)
      else $error("timeout irq while disabled");
   read_answer_a: assert property (csr_rvalid_o == $past(csr_rd_i))
      else $error("read answer timing");

   cov_burst_c:   cover property (tx_complete_irq_o);
   cov_timeout_c: cover property (tx_timeout_irq_o);
   cov_pme_c:     cover property (pme_oe_o ##1 wake_clear);
   cov_bad_c:     cover property (pm_write && !state_ok);
   cov_sticky_c:  cover property (pme_oe_o && sticky_wake_select_i && power_up_i);

endmodule : nic_perf_pm_txtimer_regs

//--- bench/host_bus_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side of the CSR bus
// ------------------------------------------------------------
module host_bus_model (
   // Clock
   input  wire logic        clk_i,
   // CSR bus
   output logic             csr_wr_o,
   output logic             csr_rd_o,
   output logic [7:0]       csr_addr_o,
   output logic [31:0]      csr_wdata_o,
   input  wire logic [31:0] csr_rdata_i,
   input  wire logic        csr_rvalid_i
);
   initial begin
      csr_wr_o    = 1'b0;
      csr_rd_o    = 1'b0;
      csr_addr_o  = 8'h00;
      csr_wdata_o = 32'h0000_0000;
   end
   // Idle bus carries inverted stale values, so nothing may lean on them
   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk_i);
      csr_addr_o  = a;
      csr_wdata_o = d;
      csr_wr_o    = 1'b1;
      @(negedge clk_i);
      csr_wr_o    = 1'b0;
      csr_addr_o  = ~a;
      csr_wdata_o = ~d;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
      @(negedge clk_i);
      csr_addr_o = a;
      csr_rd_o   = 1'b1;
      @(negedge clk_i);
      csr_rd_o   = 1'b0;
      csr_addr_o = ~a;
      d          = (csr_rvalid_i === 1'b1) ? csr_rdata_i : 32'hDEAD_BEEF;
   endtask : read_reg
endmodule : host_bus_model

//--- bench/nic_perf_pm_txtimer_regs_test.sv
`timescale 1ns/1ps
module nic_perf_pm_txtimer_regs_test;
   import nic_regs_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk_i, reset_i, csr_wr_i, csr_rd_i, csr_rvalid_o, cfg_pm_wr_i, read_req_i, master_word_i;
   logic        wake_event_i, power_up_i, sticky_wake_select_i, reset_clears_power_state_i, bus_reset_level_i;
   logic        pme_n_o, pme_oe_o, tx_success_i, tx_start_i, speed_100_i, tx_timeout_irq_enable_i;
   logic        tx_complete_irq_o, tx_timeout_irq_o;
   logic [7:0]  csr_addr_i;
   logic [15:0] cfg_pm_wdata_i, cfg_pm_rdata_o;
   logic [31:0] csr_wdata_i, csr_rdata_o, tx_desc_current_i, rx_desc_current_i;
   int          mismatches, check_count, done_cnt, tout_cnt;
   nic_perf_pm_txtimer_regs DUT (.clk_i, .reset_i, .csr_wr_i, .csr_rd_i, .csr_addr_i, .csr_wdata_i,
      .csr_rdata_o, .csr_rvalid_o, .cfg_pm_wr_i, .cfg_pm_wdata_i, .cfg_pm_rdata_o, .read_req_i,
      .master_word_i, .tx_desc_current_i, .rx_desc_current_i, .wake_event_i, .power_up_i,
      .sticky_wake_select_i, .reset_clears_power_state_i, .bus_reset_level_i, .pme_n_o, .pme_oe_o,
      .tx_success_i, .tx_start_i, .speed_100_i, .tx_timeout_irq_enable_i, .tx_complete_irq_o,
      .tx_timeout_irq_o);
   host_bus_model host (.clk_i, .csr_wr_o(csr_wr_i), .csr_rd_o(csr_rd_i), .csr_addr_o(csr_addr_i),
      .csr_wdata_o(csr_wdata_i), .csr_rdata_i(csr_rdata_o), .csr_rvalid_i(csr_rvalid_o));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(negedge clk_i) begin
      if (tx_complete_irq_o === 1'b1) done_cnt++;
      if (tx_timeout_irq_o === 1'b1) tout_cnt++;
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask : tick
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      host.read_reg(a, v);
      chk(v, exp);
   endtask : rd_chk
   task automatic wake_pulse();
      wake_event_i = 1'b1;
      tick(1);
      wake_event_i = 1'b0;
      tick(1);
   endtask : wake_pulse
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rd_chk(8'h8C, 32'h0);
      rd_chk(8'h90, 32'h0);
      rd_chk(8'h9C, 32'h0);
      rd_chk(8'hA0, 32'h0);
      chk(32'(pme_oe_o), 32'h0);
      chk(32'(pme_n_o), 32'h0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_perf();
      read_req_i = 1'b1;
      tick(5);
      read_req_i = 1'b0;
      master_word_i = 1'b1;
      tick(3);
      master_word_i = 1'b0;
      host.write_reg(8'h8C, 32'hFFFF_FFFF);
      rd_chk(8'h8C, 32'h0005_0003);
      rd_chk(8'h8C, 32'h0);
      master_word_i = 1'b1;
      tick(260);
      master_word_i = 1'b0;
      rd_chk(8'h8C, 32'h0000_00FF);
      $display("t_perf done");
   endtask : t_perf
   task automatic t_desc();
      tx_desc_current_i = 32'h1234_5678;
      rx_desc_current_i = 32'h9ABC_DEF0;
      host.write_reg(8'h94, 32'h0);
      host.write_reg(8'h98, 32'h0);
      rd_chk(8'h94, 32'h1234_5678);
      rd_chk(8'h98, 32'h9ABC_DEF0);
      $display("t_desc done");
   endtask : t_desc
   task automatic t_power();
      host.write_reg(8'h90, 32'h0000_7E03);
      rd_chk(8'h90, 32'h0000_0003);
      tick(2);
      chk(32'(cfg_pm_rdata_o), 32'h3);
      host.write_reg(8'h90, 32'h1);
      rd_chk(8'h90, 32'h3);
      host.write_reg(8'h90, 32'h2);
      rd_chk(8'h90, 32'h3);
      host.write_reg(8'h90, 32'h0);
      rd_chk(8'h90, 32'h0);
      host.write_reg(8'h90, 32'h3);
      reset_clears_power_state_i = 1'b1;
      bus_reset_level_i = 1'b1;
      tick(2);
      bus_reset_level_i = 1'b0;
      rd_chk(8'h90, 32'h0);
      reset_clears_power_state_i = 1'b0;
      $display("t_power done");
   endtask : t_power
   task automatic t_wake();
      cfg_pm_wdata_i = 16'h0100;
      cfg_pm_wr_i = 1'b1;
      tick(1);
      cfg_pm_wr_i = 1'b0;
      wake_pulse();
      chk(32'(pme_oe_o), 32'h1);
      rd_chk(8'h90, 32'h8100);
      host.write_reg(8'h90, 32'h0100);
      rd_chk(8'h90, 32'h8100);
      host.write_reg(8'h90, 32'h8100);
      chk(32'(pme_oe_o), 32'h0);
      host.write_reg(8'h90, 32'h0);
      wake_pulse();
      chk(32'(pme_oe_o), 32'h0);
      rd_chk(8'h90, 32'h8000);
      host.write_reg(8'h90, 32'h8100);
      wake_pulse();
      power_up_i = 1'b1;
      tick(1);
      power_up_i = 1'b0;
      tick(1);
      chk(32'(pme_oe_o), 32'h0);
      sticky_wake_select_i = 1'b1;
      host.write_reg(8'h90, 32'h8100);
      wake_pulse();
      power_up_i = 1'b1;
      tick(1);
      power_up_i = 1'b0;
      tick(1);
      chk(32'(pme_oe_o), 32'h1);
      host.write_reg(8'h90, 32'h8000);
      chk(32'(pme_oe_o), 32'h0);
      $display("t_wake done");
   endtask : t_wake
   task automatic t_tx();
      host.write_reg(8'h9C, 32'h0003_0002);
      done_cnt = 0;
      tx_success_i = 1'b1;
      tick(5);
      tx_success_i = 1'b0;
      tick(2);
      chk(32'(done_cnt), 32'h1);
      tx_success_i = 1'b1;
      tick(1);
      tx_success_i = 1'b0;
      tick(2);
      chk(32'(done_cnt), 32'h2);
      tout_cnt = 0;
      tx_start_i = 1'b1;
      tick(1);
      tx_start_i = 1'b0;
      tick(1000);
      chk(32'(tout_cnt), 32'h0);
      tx_timeout_irq_enable_i = 1'b1;
      tick(400);
      chk(32'(tout_cnt), 32'h0);
      tick(300);
      chk(32'(tout_cnt), 32'h1);
      tx_timeout_irq_enable_i = 1'b0;
      speed_100_i = 1'b0;
      tx_start_i = 1'b1;
      tick(1);
      tx_start_i = 1'b0;
      tx_timeout_irq_enable_i = 1'b1;
      tick(4000);
      chk(32'(tout_cnt), 32'h1);
      tick(1500);
      chk(32'(tout_cnt), 32'h2);
      $display("t_tx done");
   endtask : t_tx
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      {cfg_pm_wr_i, read_req_i, master_word_i, wake_event_i, power_up_i} = 5'h00;
      {sticky_wake_select_i, reset_clears_power_state_i, bus_reset_level_i, tx_success_i} = 4'h0;
      {tx_start_i, tx_timeout_irq_enable_i} = 2'h0;
      speed_100_i = 1'b1;
      cfg_pm_wdata_i = 16'h0000;
      tx_desc_current_i = 32'h0000_0000;
      rx_desc_current_i = 32'h0000_0000;
      reset_i = 1'b1;
      tick(16);
      reset_i = 1'b0;
      t_reset();
      t_perf();
      t_desc();
      t_power();
      t_wake();
      t_tx();
      test_done();
   end
   initial begin
      #200000;
      mismatches++;
      test_done();
   end
endmodule : nic_perf_pm_txtimer_regs_test
